// *** bench/cfg_select_properties.sv ***
// concurrent checks on the host/device configuration link
module cfg_select_properties (
    input wire logic                     mclk,
    input wire logic                     sys_rst,
    input wire logic                     reset_pin,
    input wire logic [1:0]               serial_select_strap,
    input wire logic                     serial_clock_pin,
    input wire logic                     serial_data_pin,
    input wire logic [1:0]               interface_width_strap,
    input wire logic [1:0]               serialization_factor_strap,
    input wire logic [1:0]               reserved_strap,
    input wire logic [1:0]               bit_order_format_strap,
    input wire logic                     pdn_pin,
    input wire cfg_select_pkg::eff_cfg_t eff_cfg,
    input wire logic                     serial_mode,
    input wire logic                     straps_ready,
    input wire logic                     chan_a_off,
    input wire logic                     chan_b_off,
    input wire logic                     ref_buf_off,
    input wire logic                     pll_off,
    input wire logic                     out_buf_off
);
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_select_pkg::*;
    logic pin_ok;
    assign pin_ok = reset_pin && straps_ready;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_reserved_ground: assert property (reserved_strap == 2'h0)
        else $error("reserved strap driven");
    chk_mode_from_pin: assert property (serial_mode == !reset_pin)
        else $error("serial mode not tied to reset pin");
    chk_pdn_all_off: assert property (
        eff_cfg.global_pdn |-> chan_a_off && chan_b_off && ref_buf_off && pll_off && out_buf_off)
        else $error("global power-down left a block on");
    chk_straps_settle: assert property (
        $fell(sys_rst) |-> !straps_ready ##[5:14] straps_ready)
        else $error("straps not captured in time");
    chk_pin_normal: assert property (
        (pin_ok && !pdn_pin && !serial_clock_pin && !serial_data_pin)[*3]
        |-> !eff_cfg.global_pdn && eff_cfg.pattern == 3'h0)
        else $error("pin normal mode wrong");
    chk_pin_sync: assert property (
        (pin_ok && !serial_clock_pin && serial_data_pin)[*3] |-> eff_cfg.pattern == 3'h1)
        else $error("pin sync pattern wrong");
    chk_pin_pdn: assert property (
        (pin_ok && serial_clock_pin && !serial_data_pin)[*3] |-> eff_cfg.global_pdn)
        else $error("pin power-down not applied");
    chk_pin_deskew: assert property (
        (pin_ok && serial_clock_pin && serial_data_pin)[*3] |-> eff_cfg.pattern == 3'h2)
        else $error("pin deskew pattern wrong");
    chk_pdn_pin_forces: assert property (pdn_pin |=> eff_cfg.global_pdn)
        else $error("power-down pin did not force global power-down");
    chk_select_decode: assert property (
        $past(straps_ready, 2) && pin_ok |-> eff_cfg.ref_internal == serial_select_strap[1]
        && eff_cfg.gain_3p5db == ^serial_select_strap)
        else $error("select strap decode wrong");
    chk_strap_codes: assert property (
        $past(straps_ready, 2) && pin_ok && interface_width_strap != 2'h1
        |-> eff_cfg.iface_code == interface_width_strap
        && eff_cfg.serial_code == serialization_factor_strap
        && eff_cfg.order_code == bit_order_format_strap)
        else $error("strap codes not applied");
endmodule : cfg_select_properties

// *** bench/tb.sv ***
// self-checking bench: host and device joined by the link
`include "cfg_select_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_select_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, serial_mode, straps_ready, smp = 1'b0;
    logic        chan_a_off, chan_b_off, ref_buf_off, pll_off, out_buf_off;
    eff_cfg_t    eff_cfg;
    logic [15:0] q_exp[$];
    int          err_total = 0;
    int          checks_done = 0;
    integer      seed = 96932;
    cfg_link_if  link ();
    cfg_host i_cfg_host (.mclk(mclk), .sys_rst(sys_rst), .link(link.host),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    cfg_device i_cfg_device (.mclk(mclk), .sys_rst(sys_rst), .link(link.device),
        .eff_cfg(eff_cfg), .serial_mode(serial_mode), .straps_ready(straps_ready),
        .chan_a_off(chan_a_off), .chan_b_off(chan_b_off), .ref_buf_off(ref_buf_off),
        .pll_off(pll_off), .out_buf_off(out_buf_off));
    cfg_select_properties i_cfg_select_properties (.mclk(mclk), .sys_rst(sys_rst),
        .reset_pin(link.reset_pin), .serial_select_strap(link.serial_select_strap),
        .serial_clock_pin(link.serial_clock_pin), .serial_data_pin(link.serial_data_pin),
        .interface_width_strap(link.interface_width_strap),
        .serialization_factor_strap(link.serialization_factor_strap),
        .reserved_strap(link.reserved_strap), .bit_order_format_strap(link.bit_order_format_strap),
        .pdn_pin(link.pdn_pin),
        .eff_cfg(eff_cfg), .serial_mode(serial_mode), .straps_ready(straps_ready),
        .chan_a_off(chan_a_off), .chan_b_off(chan_b_off), .ref_buf_off(ref_buf_off),
        .pll_off(pll_off), .out_buf_off(out_buf_off));
    initial begin
        forever #25 mclk = ~mclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one bus cycle; held until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
        int   n;
        logic wt;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        // values settled before the edge are those the edge samples
        do begin
            @(negedge mclk);
            wt = avs_waitrequest;
            rd = avs_readdata;
            n++;
            @(posedge mclk);
        end while (wt !== 1'b0 && n < 40);
        if (wt !== 1'b0) begin
            err_total++;
            close_out();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(`HOST_CSR_STATUS, 1'b0, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 60);
        if (n >= 60) begin
            err_total++;
            close_out();
        end
    endtask : wait_idle
    task automatic word(input logic [4:0] a, input logic [10:0] d);
        bus(`HOST_CSR_WORD, 1'b1, {16'h0000, a, d});
        wait_idle();
    endtask : word
    task automatic wait_ready();
        int n;
        n = 0;
        while (straps_ready !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            close_out();
        end
        repeat (2) @(posedge mclk);
    endtask : wait_ready
    task automatic note(input logic [15:0] exp);
        q_exp.push_back(exp);
        @(posedge mclk);
        smp <= 1'b1;
        @(posedge mclk);
        smp <= 1'b0;
    endtask : note
    task automatic restart();
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
    endtask : restart
    // the monitor pairs each sample with the oldest expectation
    always @(negedge mclk) begin
        if (smp && q_exp.size() > 0) begin
            check("eff_cfg", {chan_a_off, chan_b_off, eff_cfg.global_pdn, eff_cfg.ref_internal,
                eff_cfg.gain_3p5db, eff_cfg.iface_code, eff_cfg.serial_code, eff_cfg.order_code,
                eff_cfg.pattern, serial_mode, straps_ready}, q_exp.pop_front());
        end
    end
    initial begin
        int         k, w, f, o;
        logic [1:0] p, rw, rf, ro;
        logic [2:0] pat;
        for (k = 0; k < 4; k++) begin
            restart();
            w = {$random(seed)} % 3;
            if (w != 0) w++; // width code 1 is unused
            f = {$random(seed)} % 4;
            o = {$random(seed)} % 16;
            p = k[1:0];
            pat = (p == 2'h1) ? 3'h1 : (p == 2'h3) ? 3'h2 : 3'h0;
            bus(`HOST_CSR_STRAP, 1'b1,
                {19'h0, 1'b0, o[3:2], p, o[1:0], 2'h0, f[1:0], w[1:0]});
            bus(`HOST_CSR_CTRL, 1'b1, {28'h0, p, 2'b01});
            wait_ready();
            note({o[3] || p == 2'h2, o[2] || p == 2'h2, p == 2'h2, p[1], ^p,
                w[1:0], f[1:0], o[1:0], pat, 2'b01});
        end
        restart();
        bus(`HOST_CSR_STRAP, 1'b1, {24'h0, o[1:0], 2'h0, f[1:0], w[1:0]});
        bus(4'h2, 1'b1, 32'hFFFF_FFFF);
        bus(`HOST_CSR_CTRL, 1'b1, 32'h0000_0002);
        wait_ready();
        wait_idle();
        word(`REG_OVERRIDE_ADDR, 11'h020);
        note({5'b00000, w[1:0], f[1:0], o[1:0], 3'h0, 2'b11});
        rw = ~w[1:0];
        rf = ~f[1:0];
        ro = ~o[1:0];
        word(`REG_GLOBAL_ADDR, 11'h040);
        word(`REG_PATTERN_ADDR, 11'h040);
        word(`REG_OVERRIDE_ADDR, {3'b100, ro, 2'b10, rf, rw});
        note({5'b00011, rw, rf, ro, 3'h2, 2'b11});
        word(`REG_GLOBAL_ADDR, 11'h041);
        note({5'b11111, rw, rf, ro, 3'h2, 2'b11});
        word(`REG_GLOBAL_ADDR, 11'h040);
        bus(`HOST_CSR_STRAP, 1'b1, {19'h0, 1'b1, 4'h0, o[1:0], 2'h0, f[1:0], w[1:0]});
        note({5'b11111, rw, rf, ro, 3'h2, 2'b11});
        word(`REG_GLOBAL_ADDR, 11'h400);
        note({5'b11100, w[1:0], f[1:0], o[1:0], 3'h0, 2'b11});
        close_out();
    end
endmodule : tb

// *** verilog/cfg_device.sv ***
// converter-side configuration source selector with serial register file
`include "cfg_select_consts.svh"
module cfg_device (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    cfg_link_if.device                 link,
    output cfg_select_pkg::eff_cfg_t   eff_cfg,
    output logic                       serial_mode,
    output logic                       straps_ready,
    output logic                       chan_a_off,
    output logic                       chan_b_off,
    output logic                       ref_buf_off,
    output logic                       pll_off,
    output logic                       out_buf_off
);
    import cfg_select_pkg::*;

    logic [1:0]  sel_code, iface_code, factor_code, order_code;
    logic [3:0]  cap;
    logic        chan_a_powerdown_pin_code, chan_b_powerdown_pin_code;
    logic [10:0] reg_global_r, reg_pattern_r, reg_override_r;
    logic [15:0] shift_r;
    logic [3:0]  bit_cnt_r;
    logic        sclk_d_r;
    logic        override, pin_mode, sen_low, sclk_fall;
    eff_cfg_t    eff_nxt;

    // straps sampled once; shift protocol never disturbs them
    strap_latch #(.W(2)) u_sel    (.mclk(mclk), .sys_rst(sys_rst),
        .strap_in(link.serial_select_strap), .code_out(sel_code), .captured(cap[0]));
    strap_latch #(.W(2)) u_iface  (.mclk(mclk), .sys_rst(sys_rst),
        .strap_in(link.interface_width_strap), .code_out(iface_code), .captured(cap[1]));
    strap_latch #(.W(2)) u_factor (.mclk(mclk), .sys_rst(sys_rst),
        .strap_in(link.serialization_factor_strap), .code_out(factor_code),
        .captured(cap[2]));
    strap_latch #(.W(4)) u_order  (.mclk(mclk), .sys_rst(sys_rst),
        .strap_in({link.chan_a_powerdown_pin, link.chan_b_powerdown_pin,
                   link.bit_order_format_strap}),
        .code_out({chan_a_powerdown_pin_code, chan_b_powerdown_pin_code, order_code}), .captured(cap[3]));

    assign straps_ready = &cap;
    assign pin_mode     = link.reset_pin;
    assign serial_mode  = !link.reset_pin;
    assign override     = reg_override_r[`BIT_OVERRIDE];

    // serial select strap is static in pin mode; low level enables shifting
    assign sen_low   = serial_mode && (link.serial_select_strap == `LVL_GND);
    assign sclk_fall = sclk_d_r && !link.serial_clock_pin;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= link.serial_clock_pin;
        end
    end

    // 16-bit words: address first, then data; partial words dropped
    always_ff @(posedge mclk) begin
        if (sys_rst || !sen_low) begin
            shift_r   <= 16'h0000;
            bit_cnt_r <= 4'h0;
        end else if (sclk_fall) begin
            shift_r   <= {shift_r[14:0], link.serial_data_pin};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // register file; software reset clears all and self-clears
    always_ff @(posedge mclk) begin
        if (sys_rst || pin_mode) begin
            reg_global_r   <= 11'h000;
            reg_pattern_r  <= 11'h000;
            reg_override_r <= 11'h000;
        end else if (sclk_fall && sen_low && bit_cnt_r == 4'hF) begin
            case ({shift_r[14:0], link.serial_data_pin} >> `DATA_W)
                16'(`REG_GLOBAL_ADDR): begin
                    // data bit 10 sits one place below the last address bit
                    if (shift_r[`BIT_SW_RESET-1]) begin
                        reg_global_r   <= 11'h000;
                        reg_pattern_r  <= 11'h000;
                        reg_override_r <= 11'h000;
                    end else begin
                        reg_global_r <= {shift_r[9:0], link.serial_data_pin};
                    end
                end
                16'(`REG_PATTERN_ADDR):  reg_pattern_r  <= {shift_r[9:0], link.serial_data_pin};
                16'(`REG_OVERRIDE_ADDR): reg_override_r <= {shift_r[9:0], link.serial_data_pin};
                default: ;
            endcase
        end
    end

    // priority multiplexers
    always_comb begin
        pin_sel_t ps;
        ps      = pin_sel_t'({link.serial_clock_pin, link.serial_data_pin});
        eff_nxt = '0;
        eff_nxt.chan_a_pdn  = chan_a_powerdown_pin_code || (serial_mode && reg_global_r[`BIT_PDN_CHA]);
        eff_nxt.chan_b_pdn  = chan_b_powerdown_pin_code || (serial_mode && reg_global_r[`BIT_PDN_CHB]);
        if (serial_mode && override) begin
            eff_nxt.iface_code  = reg_override_r[1:0];
            eff_nxt.serial_code = reg_override_r[3:2];
            eff_nxt.order_code  = reg_override_r[7:6];
        end else begin
            eff_nxt.iface_code  = iface_code;
            eff_nxt.serial_code = factor_code;
            eff_nxt.order_code  = order_code;
        end
        if (pin_mode) begin
            eff_nxt.ref_internal = sel_code[1];
            eff_nxt.gain_3p5db   = sel_code[1] ^ sel_code[0];
            eff_nxt.global_pdn   = (ps == PAT_PDN) || link.pdn_pin;
            case (ps)
                PAT_SYNC:   eff_nxt.pattern = 3'b001;
                PAT_DESKEW: eff_nxt.pattern = 3'b010;
                default:    eff_nxt.pattern = 3'b000;
            endcase
        end else begin
            eff_nxt.ref_internal = reg_global_r[`BIT_REF_SEL];
            eff_nxt.gain_3p5db   = override && reg_override_r[`BIT_COARSE_GAIN];
            eff_nxt.pattern      = reg_pattern_r[`PAT_MSB:`PAT_LSB];
            eff_nxt.global_pdn   = link.pdn_pin || reg_global_r[`BIT_PDN_GLOBAL];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            eff_cfg <= '0;
        end else begin
            eff_cfg <= eff_nxt;
        end
    end

    // global power-down drops every block at once
    assign chan_a_off  = eff_cfg.global_pdn || eff_cfg.chan_a_pdn;
    assign chan_b_off  = eff_cfg.global_pdn || eff_cfg.chan_b_pdn;
    assign ref_buf_off = eff_cfg.global_pdn;
    assign pll_off     = eff_cfg.global_pdn;
    assign out_buf_off = eff_cfg.global_pdn;
endmodule : cfg_device

// *** verilog/cfg_host.sv ***
// host controller: drives straps and serial words, Avalon-MM slave
`include "cfg_select_consts.svh"
module cfg_host (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    cfg_link_if.host         link,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import cfg_select_pkg::*;
    logic [3:0]  ctrl_r;
    logic [15:0] word_r;
    logic [12:0] strap_r;
    logic [4:0]  cnt_r;
    logic        busy_r, phase_r, acc_r;

    assign avs_waitrequest = (avs_read || avs_write) && !acc_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) acc_r <= 1'b0;
        else         acc_r <= (avs_read || avs_write) && !acc_r;
    end

    // ctrl: [0] pin mode (reset high), [1] reset pulse, [3:2] pin selector
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r  <= 4'h1;
            strap_r <= 13'h0000;
        end else if (avs_write && acc_r) begin
            if (avs_address == `HOST_CSR_CTRL)  ctrl_r  <= avs_writedata[3:0];
            if (avs_address == `HOST_CSR_STRAP) strap_r <= {avs_writedata[12:6], 2'b00,
                                                            avs_writedata[3:0]};
        end else begin
            ctrl_r[1] <= 1'b0;
        end
    end

    // shifts one word; sclk half-period is one mclk
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy_r <= 1'b0; word_r <= 16'h0000; cnt_r <= 5'h00; phase_r <= 1'b0;
        end else if (!busy_r && avs_write && acc_r && avs_address == `HOST_CSR_WORD) begin
            busy_r <= !ctrl_r[0]; word_r <= avs_writedata[15:0];
            cnt_r <= 5'h00; phase_r <= 1'b0;
        end else if (busy_r) begin
            phase_r <= !phase_r;
            if (phase_r) begin
                word_r <= {word_r[14:0], 1'b0};
                cnt_r  <= cnt_r + 5'h01;
                if (cnt_r == 5'h0F) busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) avs_readdata <= 32'h0000_0000;
        else case (avs_address)
            `HOST_CSR_CTRL:   avs_readdata <= {28'h000_0000, ctrl_r};
            `HOST_CSR_WORD:   avs_readdata <= {16'h0000, word_r};
            `HOST_CSR_STRAP:  avs_readdata <= {19'h0_0000, strap_r};
            `HOST_CSR_STATUS: avs_readdata <= {31'h0000_0000, busy_r};
            default:          avs_readdata <= 32'h0000_0000;
        endcase
    end

    assign link.reset_pin = ctrl_r[0] || ctrl_r[1];
    assign link.serial_select_strap = busy_r ? `LVL_GND :
                                      (ctrl_r[0] ? strap_r[9:8] : `LVL_SUPPLY);
    assign link.serial_clock_pin = busy_r ? !phase_r : ctrl_r[3];
    assign link.serial_data_pin  = busy_r ? word_r[15] : ctrl_r[2];
    assign link.interface_width_strap      = strap_r[1:0];
    assign link.serialization_factor_strap = strap_r[3:2];
    assign link.reserved_strap             = 2'b00;
    assign link.bit_order_format_strap     = strap_r[7:6];
    // strap word [12] power-down pin, [11] chan a, [10] chan b
    assign link.chan_a_powerdown_pin       = strap_r[11];
    assign link.chan_b_powerdown_pin       = strap_r[10];
    assign link.pdn_pin                    = strap_r[12];
endmodule : cfg_host

// *** verilog/cfg_link_if.sv ***
// pin-level link between host controller and converter config logic
interface cfg_link_if;
    logic       reset_pin;
    logic [1:0] serial_select_strap;
    logic       serial_clock_pin;
    logic       serial_data_pin;
    logic [1:0] interface_width_strap;
    logic [1:0] serialization_factor_strap;
    logic [1:0] reserved_strap;
    logic [1:0] bit_order_format_strap;
    logic       chan_a_powerdown_pin;
    logic       chan_b_powerdown_pin;
    logic       pdn_pin;
    modport host (output reset_pin, serial_select_strap, serial_clock_pin, serial_data_pin,
                  interface_width_strap, serialization_factor_strap, reserved_strap,
                  bit_order_format_strap, chan_a_powerdown_pin, chan_b_powerdown_pin, pdn_pin);
    modport device (input reset_pin, serial_select_strap, serial_clock_pin, serial_data_pin,
                    interface_width_strap, serialization_factor_strap, reserved_strap,
                    bit_order_format_strap, chan_a_powerdown_pin, chan_b_powerdown_pin,
                    pdn_pin);
endinterface : cfg_link_if

// *** verilog/cfg_select_consts.svh ***
// constants for the configuration source selector
`ifndef CFG_SELECT_CONSTS_SVH
`define CFG_SELECT_CONSTS_SVH
`define ADDR_W          5
`define DATA_W          11
`define REG_GLOBAL_ADDR 5'h00
`define REG_PATTERN_ADDR 5'h0A
`define REG_OVERRIDE_ADDR 5'h0D
`define BIT_SW_RESET    10
`define BIT_REF_SEL     6
`define BIT_PDN_CHB     3
`define BIT_PDN_CHA     2
`define BIT_PDN_GLOBAL  0
`define BIT_OVERRIDE    10
`define BIT_COARSE_GAIN 5
`define PAT_MSB         7
`define PAT_LSB         5
`define LVL_GND         2'h0
`define LVL_LOW_MID     2'h1
`define LVL_HIGH_MID    2'h2
`define LVL_SUPPLY      2'h3
`define SETTLE_CYCLES   4'h8
`define HOST_CSR_CTRL   4'h0
`define HOST_CSR_WORD   4'h4
`define HOST_CSR_STRAP  4'h8
`define HOST_CSR_STATUS 4'hC
`endif

// *** verilog/cfg_select_pkg.sv ***
// types shared by both ends of the configuration link
package cfg_select_pkg;
    typedef enum logic [1:0] {
        MODE_PIN_ONLY = 2'b00,
        MODE_SERIAL   = 2'b01,
        MODE_BOTH     = 2'b10
    } prog_mode_t;
    typedef enum logic [1:0] {
        PAT_NORMAL = 2'b00,
        PAT_SYNC   = 2'b01,
        PAT_PDN    = 2'b10,
        PAT_DESKEW = 2'b11
    } pin_sel_t;
    typedef struct packed {
        logic       global_pdn;
        logic       chan_a_pdn;
        logic       chan_b_pdn;
        logic       ref_internal;
        logic       gain_3p5db;
        logic [1:0] iface_code;
        logic [1:0] serial_code;
        logic [1:0] order_code;
        logic [2:0] pattern;
    } eff_cfg_t;
endpackage : cfg_select_pkg

// *** verilog/strap_latch.sv ***
// captures strap codes once after reset release and holds them
`include "cfg_select_consts.svh"
module strap_latch #(
    parameter int W = 2
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] strap_in,
    output logic      [W-1:0] code_out,
    output logic              captured
);
    import cfg_select_pkg::*;
    logic [3:0] settle_r;

    // wait a few cycles so straps are stable before sampling
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            settle_r <= 4'h0;
        end else if (settle_r != `SETTLE_CYCLES) begin
            settle_r <= settle_r + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            code_out <= '0;
            captured <= 1'b0;
        end else if (!captured && settle_r == `SETTLE_CYCLES) begin
            code_out <= strap_in;
            captured <= 1'b1;
        end
    end
endmodule : strap_latch
